/* rtl/pdc_pkg.sv */
/*
 * pdc_pkg: shared constants, types and helpers of the pll divider
 * configuration block.
 * assumes: one 20 MHz system clock, byte-wide register port.
 */
package pdc_pkg;

	// register offsets on the plain register port
	localparam logic [7:0] PDC_OFS_BANK_DIV = 8'h01;
	localparam logic [7:0] PDC_OFS_RATIO = 8'h04;
	localparam logic [7:0] PDC_OFS_STATUS = 8'h08;

	// values after reset
	localparam logic [7:0] PDC_RST_BANK_DIV = 8'h00;
	localparam logic [3:0] PDC_RST_RATIO = 4'h0;

	// field positions
	localparam int PDC_POS_BANK_A = 6;
	localparam int PDC_POS_BANK_B = 4;
	localparam int PDC_POS_BANK_C = 2;
	localparam int PDC_POS_BANK_D = 0;
	localparam int PDC_POS_RATIO = 0;
	localparam int PDC_POS_STAT_REJ = 0;
	localparam int PDC_POS_STAT_CODE = 4;

	// ratio codes with a defined divider pair
	localparam logic [3:0] PDC_CODE_P1_M16 = 4'h0;
	localparam logic [3:0] PDC_CODE_P1_M12 = 4'h1;
	localparam logic [3:0] PDC_CODE_P2_M12 = 4'h2;
	localparam logic [3:0] PDC_CODE_P1_M8 = 4'h3;
	localparam logic [3:0] PDC_CODE_P2_M16 = 4'h4;
	localparam logic [3:0] PDC_CODE_P2_M8 = 4'h6;
	localparam logic [3:0] PDC_CODE_P3_M12 = 4'h7;
	localparam logic [3:0] PDC_CODE_P4_M16 = 4'h8;
	localparam logic [3:0] PDC_CODE_P4_M12 = 4'hA;
	localparam logic [3:0] PDC_CODE_P4_M8 = 4'hE;
	localparam logic [3:0] PDC_CODE_P6_M12 = 4'hF;

	// divider values
	localparam logic [2:0] PDC_P1 = 3'h1;
	localparam logic [2:0] PDC_P2 = 3'h2;
	localparam logic [2:0] PDC_P3 = 3'h3;
	localparam logic [2:0] PDC_P4 = 3'h4;
	localparam logic [2:0] PDC_P6 = 3'h6;
	localparam logic [4:0] PDC_M8 = 5'h08;
	localparam logic [4:0] PDC_M12 = 5'h0C;
	localparam logic [4:0] PDC_M16 = 5'h10;

	// half of the bank divider, in vco edges per output level
	localparam logic [3:0] PDC_HALF_N2 = 4'h1;
	localparam logic [3:0] PDC_HALF_N4 = 4'h2;
	localparam logic [3:0] PDC_HALF_N8 = 4'h4;
	localparam logic [3:0] PDC_HALF_N16 = 4'h8;

	// decoded divider pair
	typedef struct packed {
		logic ok;
		logic [2:0] p;
		logic [4:0] m;
	} pdc_ratio_t;

	// one bank divider field
	typedef logic [1:0] pdc_nsel_t;

	// state of one bank divider
	typedef struct packed {
		logic [3:0] cnt;
		logic [3:0] half;
		logic clk;
	} pdc_bank_state_t;

	// state of the top module
	typedef struct packed {
		logic [7:0] bank_reg;
		logic [3:0] ratio_reg;
		logic apply_pend;
		logic [7:0] act_bank;
		logic [3:0] act_code;
		logic [2:0] p_val;
		logic [4:0] m_val;
		logic rejected;
		logic [7:0] rdata;
		logic [2:0] ref_sync;
		logic [2:0] vco_sync;
		logic [2:0] p_cnt;
		logic [4:0] m_cnt;
		logic ref_pulse;
		logic fb_pulse;
	} pdc_top_state_t;

	// bank field to half divider
	function automatic logic [3:0] pdc_n_half(input pdc_nsel_t sel);
		logic [3:0] h;
		h = PDC_HALF_N2;
		unique case (sel)
			2'h0: h = PDC_HALF_N2;
			2'h1: h = PDC_HALF_N4;
			2'h2: h = PDC_HALF_N8;
			2'h3: h = PDC_HALF_N16;
		endcase
		return h;
	endfunction

endpackage

/* rtl/pdc_ratio_decode.sv */
/*
 * pdc_ratio_decode: turns the 4-bit pll ratio code into the input
 * divider P and feedback divider M.
 * assumes: pure logic, caller registers the result.
 */
module pdc_ratio_decode import pdc_pkg::*; (
	input wire logic [3:0] pll_ratio_code,
	output pdc_ratio_t ratio
);

	// one divider pair per defined code, reserved codes flag not ok
	always_comb begin
		ratio = '{ok: 1'b1, p: PDC_P1, m: PDC_M16};
		case (pll_ratio_code)
			PDC_CODE_P1_M16: ratio = '{ok: 1'b1, p: PDC_P1, m: PDC_M16};
			PDC_CODE_P1_M12: ratio = '{ok: 1'b1, p: PDC_P1, m: PDC_M12};
			PDC_CODE_P2_M12: ratio = '{ok: 1'b1, p: PDC_P2, m: PDC_M12};
			PDC_CODE_P1_M8: ratio = '{ok: 1'b1, p: PDC_P1, m: PDC_M8};
			PDC_CODE_P2_M16: ratio = '{ok: 1'b1, p: PDC_P2, m: PDC_M16};
			PDC_CODE_P2_M8: ratio = '{ok: 1'b1, p: PDC_P2, m: PDC_M8};
			PDC_CODE_P3_M12: ratio = '{ok: 1'b1, p: PDC_P3, m: PDC_M12};
			PDC_CODE_P4_M16: ratio = '{ok: 1'b1, p: PDC_P4, m: PDC_M16};
			PDC_CODE_P4_M12: ratio = '{ok: 1'b1, p: PDC_P4, m: PDC_M12};
			PDC_CODE_P4_M8: ratio = '{ok: 1'b1, p: PDC_P4, m: PDC_M8};
			PDC_CODE_P6_M12: ratio = '{ok: 1'b1, p: PDC_P6, m: PDC_M12};
			// reserved code: no pair, caller keeps the old one
			default: ratio = '{ok: 1'b0, p: PDC_P1, m: PDC_M16};
		endcase
	end

endmodule

/* rtl/pdc_bank_divider.sv */
/*
 * pdc_bank_divider: divides the vco edge stream by the bank's N.
 * assumes: vco_edge is a one-cycle pulse on clk_sys per vco edge.
 */
module pdc_bank_divider import pdc_pkg::*; (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic vco_edge,
	input wire pdc_nsel_t sel,
	output logic bank_clk_ff
);

	pdc_bank_state_t st_ff; // registered state
	pdc_bank_state_t nxt_st; // next state

	// toggle every N/2 vco edges; new N taken only at a toggle
	always_comb begin
		nxt_st = st_ff;
		if (!reset_n) begin
			nxt_st = '{cnt: 4'h0, half: PDC_HALF_N2, clk: 1'b0};
		end else if (vco_edge) begin
			if (st_ff.cnt == st_ff.half - 4'h1) begin
				// level boundary: flip and take the latest N
				nxt_st.clk = ~st_ff.clk;
				nxt_st.cnt = 4'h0;
				nxt_st.half = pdc_n_half(sel);
			end else begin
				nxt_st.cnt = st_ff.cnt + 4'h1;
			end
		end
	end

	// register the state
	always_ff @(posedge clk_sys) begin
		st_ff <= nxt_st;
	end

	assign bank_clk_ff = st_ff.clk;

endmodule

/* rtl/pdc_top.sv */
/*
 * pdc_top: register file and divider logic of the pll divider
 * configuration. Holds the bank divider register and the pll ratio
 * register, applies the bank register and, for a defined code, the ratio register one cycle after the write, and
 * drives the P-divided reference pulse, the M-divided feedback pulse
 * and four bank clocks divided by N from the vco.
 * assumes: ref_clk_pin and vco_clk_pin are asynchronous pins slower
 * than half of clk_sys; register strobes are one cycle and never
 * both at once.
 */

// What this block does
// - output frequency is reference/P times M over N
// - P from ratio code bits 3:0
// - M chosen jointly with P by code
// - bank A divider from bits 7:6
// - bank B divider from bits 5:4
// - bank C divider from bits 3:2
// - bank D divider from bits 1:0
// - each bank divides independently by 2..16
// - bank clock is vco over bank N
// - code 0 P1 M16, code 1 P1 M12
// - code 2 P2 M12, code 3 P1 M8
// - code 4 P2 M16, code 6 P2 M8
// - code 7 P3 M12, code 8 P4 M16
// - code 10 P4 M12, code 14 P4 M8
// - code 15 P6 M12
// - field 00/01/10/11 divides by 2/4/8/16
module pdc_top import pdc_pkg::*; (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata_ff,
	input wire logic ref_clk_pin,
	input wire logic vco_clk_pin,
	output logic ref_div_pulse_ff,
	output logic fb_div_pulse_ff,
	output logic [2:0] p_value_ff,
	output logic [4:0] m_value_ff,
	output logic [3:0] bank_clk_ff
);

	pdc_top_state_t st_ff; // registered state
	pdc_top_state_t nxt_st; // next state

	pdc_ratio_t ratio_dec; // decode of the written ratio code
	logic ref_edge; // one-cycle pulse per reference rising edge
	logic vco_edge; // one-cycle pulse per vco rising edge
	logic wr_bank; // write hits the bank divider register
	logic wr_ratio; // write hits the pll ratio register
	logic [7:0] rd_word; // word selected for a read

	// pin edges, seen only behind the second synchroniser stage
	assign ref_edge = st_ff.ref_sync[1] & ~st_ff.ref_sync[2];
	assign vco_edge = st_ff.vco_sync[1] & ~st_ff.vco_sync[2];

	// write decode
	assign wr_bank = reg_wr && (reg_addr == PDC_OFS_BANK_DIV);
	assign wr_ratio = reg_wr && (reg_addr == PDC_OFS_RATIO);

	// decoder of the software-visible ratio code
	pdc_ratio_decode u_ratio_decode (
		.pll_ratio_code(st_ff.ratio_reg),
		.ratio(ratio_dec)
	);

	// read multiplexer; unmapped offsets read zero
	always_comb begin
		rd_word = 8'h00;
		unique case (reg_addr)
			PDC_OFS_BANK_DIV: begin
				// bank fields as written
				rd_word = st_ff.bank_reg;
			end
			PDC_OFS_RATIO: begin
				// ratio code in the low bits, upper bits zero
				rd_word[PDC_POS_RATIO +: 4] = st_ff.ratio_reg;
			end
			PDC_OFS_STATUS: begin
				// applied code and the rejected flag
				rd_word[PDC_POS_STAT_CODE +: 4] = st_ff.act_code;
				rd_word[PDC_POS_STAT_REJ] = st_ff.rejected;
			end
			default: begin
				// nothing mapped here
				rd_word = 8'h00;
			end
		endcase
	end

	// next state of the whole block
	always_comb begin
		nxt_st = st_ff;
		if (!reset_n) begin
			// defined state after reset
			nxt_st.bank_reg = PDC_RST_BANK_DIV;
			nxt_st.ratio_reg = PDC_RST_RATIO;
			nxt_st.apply_pend = 1'b0;
			nxt_st.act_bank = PDC_RST_BANK_DIV;
			nxt_st.act_code = PDC_RST_RATIO;
			nxt_st.p_val = PDC_P1;
			nxt_st.m_val = PDC_M16;
			nxt_st.rejected = 1'b0;
			nxt_st.rdata = 8'h00;
			nxt_st.ref_sync = 3'h0;
			nxt_st.vco_sync = 3'h0;
			nxt_st.p_cnt = 3'h0;
			nxt_st.m_cnt = 5'h00;
			nxt_st.ref_pulse = 1'b0;
			nxt_st.fb_pulse = 1'b0;
		end else begin
			// synchronisers: stage 0 feeds stage 1 only
			nxt_st.ref_sync = {st_ff.ref_sync[1:0], ref_clk_pin};
			nxt_st.vco_sync = {st_ff.vco_sync[1:0], vco_clk_pin};

			// read data stand for one cycle only
			nxt_st.rdata = reg_rd ? rd_word : 8'h00;

			// software-visible registers take the write at once
			if (wr_bank) begin
				nxt_st.bank_reg = reg_wdata;
			end
			if (wr_ratio) begin
				nxt_st.ratio_reg = reg_wdata[PDC_POS_RATIO +: 4];
			end

			// mark a completed write for transfer next cycle
			nxt_st.apply_pend = wr_bank || wr_ratio;

			// transfer the bank register, and the ratio register if its code is defined
			if (st_ff.apply_pend) begin
				nxt_st.act_bank = st_ff.bank_reg;
				if (ratio_dec.ok) begin
					// defined code: new P and M together
					nxt_st.act_code = st_ff.ratio_reg;
					nxt_st.p_val = ratio_dec.p;
					nxt_st.m_val = ratio_dec.m;
					nxt_st.rejected = 1'b0;
				end else begin
					// reserved code: keep running on the old pair
					nxt_st.rejected = 1'b1;
				end
			end

			// input divider: one pulse every P reference edges
			nxt_st.ref_pulse = 1'b0;
			if (ref_edge) begin
				if (st_ff.p_cnt >= st_ff.p_val - 3'h1) begin
					nxt_st.p_cnt = 3'h0;
					nxt_st.ref_pulse = 1'b1;
				end else begin
					nxt_st.p_cnt = st_ff.p_cnt + 3'h1;
				end
			end

			// feedback divider: one pulse every M vco edges
			nxt_st.fb_pulse = 1'b0;
			if (vco_edge) begin
				if (st_ff.m_cnt >= st_ff.m_val - 5'h01) begin
					nxt_st.m_cnt = 5'h00;
					nxt_st.fb_pulse = 1'b1;
				end else begin
					nxt_st.m_cnt = st_ff.m_cnt + 5'h01;
				end
			end
		end
	end

	// register the state
	always_ff @(posedge clk_sys) begin
		st_ff <= nxt_st;
	end

	// bank dividers, index 3 is bank A down to index 0 bank D
	pdc_bank_divider u_bank_a (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.vco_edge(vco_edge),
		.sel(st_ff.act_bank[PDC_POS_BANK_A +: 2]),
		.bank_clk_ff(bank_clk_ff[3])
	);

	pdc_bank_divider u_bank_b (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.vco_edge(vco_edge),
		.sel(st_ff.act_bank[PDC_POS_BANK_B +: 2]),
		.bank_clk_ff(bank_clk_ff[2])
	);

	pdc_bank_divider u_bank_c (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.vco_edge(vco_edge),
		.sel(st_ff.act_bank[PDC_POS_BANK_C +: 2]),
		.bank_clk_ff(bank_clk_ff[1])
	);

	pdc_bank_divider u_bank_d (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.vco_edge(vco_edge),
		.sel(st_ff.act_bank[PDC_POS_BANK_D +: 2]),
		.bank_clk_ff(bank_clk_ff[0])
	);

	// outputs straight from state flip-flops
	assign reg_rdata_ff = st_ff.rdata;
	assign ref_div_pulse_ff = st_ff.ref_pulse;
	assign fb_div_pulse_ff = st_ff.fb_pulse;
	assign p_value_ff = st_ff.p_val;
	assign m_value_ff = st_ff.m_val;

endmodule

/* tb/pdc_top_props.sv */
/*
 * pdc_top_props: port assertions of pdc_top.
 * assumes: bound to pdc_top; pins toggle slower than clk_sys/2.
 */
module pdc_top_props import pdc_pkg::*; (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata_ff,
	input wire logic ref_clk_pin,
	input wire logic vco_clk_pin,
	input wire logic ref_div_pulse_ff,
	input wire logic fb_div_pulse_ff,
	input wire logic [2:0] p_value_ff,
	input wire logic [4:0] m_value_ff,
	input wire logic [3:0] bank_clk_ff
);
	// P and M per code, 0 marks a reserved code
	localparam logic [63:0] TP = 64'h6400_0404_3202_1211;
	localparam logic [127:0] TM = 128'h0C08_0000_000C_0010_0C08_0010_080C_0C10;
	logic [7:0] bank_sh; // shadow of bank divider register
	logic [3:0] ratio_sh; // shadow of ratio register
	logic wr_ratio; // ratio write this cycle
	logic code_ok; // written code has a pair
	assign wr_ratio = reg_wr && reg_addr == PDC_OFS_RATIO;
	assign code_ok = TP[4*reg_wdata[3:0] +: 3] != 3'h0;
	// shadows follow register writes
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			bank_sh <= 8'h00;
			ratio_sh <= 4'h0;
		end else if (reg_wr && reg_addr == PDC_OFS_BANK_DIV) begin
			bank_sh <= reg_wdata;
		end else if (wr_ratio) begin
			ratio_sh <= reg_wdata[3:0];
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_ff == 8'h00)
		else $error("read data not zero outside read");
	bank_read_a: assert property (reg_rd && reg_addr == PDC_OFS_BANK_DIV |=>
		reg_rdata_ff == bank_sh) else $error("bank register readback wrong");
	ratio_read_a: assert property (reg_rd && reg_addr == PDC_OFS_RATIO |=>
		reg_rdata_ff == {4'h0, ratio_sh}) else $error("ratio register readback wrong");
	apply_p_a: assert property (wr_ratio && code_ok |=> $stable(p_value_ff) ##1
		p_value_ff == TP[4*ratio_sh +: 3]) else $error("P not applied");
	apply_m_a: assert property (wr_ratio && code_ok |=> $stable(m_value_ff) ##1
		m_value_ff == TM[8*ratio_sh +: 5]) else $error("M not applied");
	reserved_hold_a: assert property (wr_ratio && !code_ok |=>
		($stable(p_value_ff) && $stable(m_value_ff))[*2]) else $error("reserved code applied");
	pm_cause_a: assert property ($changed(p_value_ff) || $changed(m_value_ff) |->
		$past(reg_wr, 2)) else $error("P or M changed without write");
	ref_pulse_a: assert property (ref_div_pulse_ff |=> !ref_div_pulse_ff)
		else $error("reference pulse too long");
	fb_pulse_a: assert property (fb_div_pulse_ff |=> !fb_div_pulse_ff)
		else $error("feedback pulse too long");
	bank_hold_a: assert property ($changed(bank_clk_ff[0]) |=> $stable(bank_clk_ff[0]))
		else $error("bank D toggled twice");
endmodule

bind pdc_top pdc_top_props i_props (.clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata_ff, .ref_clk_pin, .vco_clk_pin, .ref_div_pulse_ff, .fb_div_pulse_ff,
	.p_value_ff, .m_value_ff, .bank_clk_ff);

/* tb/testbench.sv */
/*
 * testbench: register and divider tests of pdc_top.
 * assumes: pdc_pkg, pdc_top and the bound checker are compiled.
 */
module testbench import pdc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
	$display("mismatch %0t got %h exp %h", $time, g, e); end end
	localparam logic [63:0] TP = 64'h6400_0404_3202_1211; // P per code
	localparam logic [127:0] TM = 128'h0C08_0000_000C_0010_0C08_0010_080C_0C10; // M
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic ref_clk_pin = 1'b0;
	logic vco_clk_pin = 1'b0;
	logic [7:0] reg_rdata_ff;
	logic ref_div_pulse_ff;
	logic fb_div_pulse_ff;
	logic [2:0] p_value_ff;
	logic [4:0] m_value_ff;
	logic [3:0] bank_clk_ff;
	int errors = 0;
	int n_compared = 0;
	int tog[4] = '{0, 0, 0, 0}; // bank toggles, index = port bit
	int n_ref = 0;
	int n_fb = 0;
	logic cnt_en = 1'b0; // counting window
	logic [3:0] bank_d = 4'h0; // bank clocks one edge ago
	logic [7:0] rd_v;
	logic [3:0] last; // last accepted code
	always #25 clk_sys = ~clk_sys;
	pdc_top i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
		.ref_clk_pin(ref_clk_pin), .vco_clk_pin(vco_clk_pin),
		.ref_div_pulse_ff(ref_div_pulse_ff), .fb_div_pulse_ff(fb_div_pulse_ff),
		.p_value_ff(p_value_ff), .m_value_ff(m_value_ff), .bank_clk_ff(bank_clk_ff));
	// counts bank toggles and divider pulses inside the window
	always @(posedge clk_sys) begin
		bank_d <= bank_clk_ff;
		if (cnt_en) begin
			for (int b = 0; b < 4; b++) tog[b] += int'(bank_clk_ff[b] !== bank_d[b]);
			n_ref += int'(ref_div_pulse_ff === 1'b1);
			n_fb += int'(fb_div_pulse_ff === 1'b1);
		end
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata_ff;
	endtask
	// both pins rise together, period of four system clocks
	task automatic edges(input int n);
		repeat (n) begin
			@(posedge clk_sys);
			ref_clk_pin <= 1'b1;
			vco_clk_pin <= 1'b1;
			repeat (2) @(posedge clk_sys);
			ref_clk_pin <= 1'b0;
			vco_clk_pin <= 1'b0;
			@(posedge clk_sys);
		end
	endtask
	task automatic end_of_test();
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk_sys);
		errors++;
		$display("mismatch %0t watchdog expired", $time);
		end_of_test();
	end
	initial begin
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		#1;
		`CHK(p_value_ff, PDC_P1)
		`CHK(m_value_ff, PDC_M16)
		`CHK(bank_clk_ff, 4'h0)
		rd(PDC_OFS_BANK_DIV, rd_v);
		`CHK(rd_v, PDC_RST_BANK_DIV)
		$display("test reset done");
		// every code, reserved ones must leave P and M alone
		last = PDC_RST_RATIO;
		for (int c = 0; c < 16; c++) begin
			wr(PDC_OFS_RATIO, {4'hA, 4'(c)});
			#1;
			`CHK(p_value_ff, TP[4*last +: 3])
			rd(PDC_OFS_RATIO, rd_v);
			`CHK(rd_v, {4'h0, 4'(c)})
			if (TP[4*c +: 3] != 3'h0) last = 4'(c);
			`CHK(p_value_ff, TP[4*last +: 3])
			`CHK(m_value_ff, TM[8*last +: 5])
			rd(PDC_OFS_STATUS, rd_v);
			`CHK(rd_v, {last, 3'h0, 1'(TP[4*c +: 3] == 3'h0)})
		end
		$display("test ratio codes done");
		// unmapped and read-only places
		wr(PDC_OFS_STATUS, 8'hFF);
		wr(8'h02, 8'h55);
		rd(8'h02, rd_v);
		`CHK(rd_v, 8'h00)
		rd(PDC_OFS_STATUS, rd_v);
		`CHK(rd_v, 8'hF0)
		$display("test unmapped done");
		// P3 M12 with a different N per bank
		wr(PDC_OFS_RATIO, {4'h0, PDC_CODE_P3_M12});
		wr(PDC_OFS_BANK_DIV, 8'h1B);
		rd(PDC_OFS_BANK_DIV, rd_v);
		`CHK(rd_v, 8'h1B)
		edges(16);
		cnt_en <= 1'b1;
		edges(96);
		cnt_en <= 1'b0;
		@(posedge clk_sys);
		#1;
		`CHK(tog[3], 96)
		`CHK(tog[2], 48)
		`CHK(tog[1], 24)
		`CHK(tog[0], 12)
		`CHK(n_ref, 32)
		`CHK(n_fb, 8)
		$display("test dividers done");
		end_of_test();
	end
endmodule
